// [include/jtlt_pkg.sv]
// Package of constants and types for the transmit link timing block
package jtlt_pkg;
   // Clock rate in kHz (125 MHz)
   localparam int unsigned CLK_KHZ        = 125000;
   // Multiframe length in sample cycles
   localparam int unsigned MF_CYC         = 32;
   localparam logic [5:0]  MF_LAST        = 6'h1f;
   localparam int unsigned SYNC_WAIT_MF   = 4;
   localparam logic [2:0]  SYNC_WAIT_LAST = 3'h3;
   localparam int unsigned CGS_MIN_MF     = 1;
   // Bit period denominator factor
   localparam int unsigned UI_FACTOR      = 20;
   // Wake and lock times in ns
   localparam int unsigned T_STBY_NS      = 2000;
   localparam int unsigned T_PDWN_NS      = 375000;
   localparam int unsigned T_LINK_NS      = 250000;
   localparam int unsigned T_LOCK_NS      = 26000;
   localparam int unsigned STBY_CYC       = T_STBY_NS * (CLK_KHZ / 1000) / 1000;
   localparam int unsigned PDWN_CYC       = T_PDWN_NS * (CLK_KHZ / 1000) / 1000;
   localparam int unsigned LINK_CYC       = T_LINK_NS * (CLK_KHZ / 1000) / 1000;
   localparam int unsigned LOCK_CYC       = T_LOCK_NS * (CLK_KHZ / 1000) / 1000;
   // Latency tables, index is mode minus one
   localparam logic [5:0] LAT4 [4] = '{6'h1f, 6'h2a, 6'h1e, 6'h24};
   localparam logic [5:0] LAT2 [4] = '{6'h1f, 6'h21, 6'h1e, 6'h1e};
   localparam int unsigned WAKE_W = 17;
   localparam logic [7:0]  K28_5  = 8'hbc;
   localparam logic [7:0]  START_CODE = 8'h1c;
   typedef enum logic [2:0] {JT_OFF, JT_WAIT, JT_CGS, JT_DATA} jtlt_state_t;
endpackage

// [hdl/jtlt_buf.sv]
// Two-entry valid/ready buffer for link characters
`timescale 1ns/1ps
`default_nettype none
module jtlt_buf (
   // Clock, reset and enable
   input  wire logic       ref_clk_i,
   input  wire logic       nrst_i,
   input  wire logic       en_i,
   // Fill side
   input  wire logic       in_valid_i,
   output logic            in_ready_o,
   input  wire logic [8:0] in_data_i,
   // Drain side
   output logic            out_valid_o,
   input  wire logic       out_ready_i,
   output logic [8:0]      out_data_o
);
   typedef struct packed {
      logic [1:0][8:0] mem;
      logic [1:0]      cnt;
   } jtlt_buf_t;
   jtlt_buf_t s_q, s_d;
   logic push, pop;

   // Handshakes come straight from the fill count
   assign in_ready_o  = (s_q.cnt != 2'h2);
   assign out_valid_o = (s_q.cnt != 2'h0);
   assign out_data_o  = s_q.mem[0];
   assign push = in_valid_i & in_ready_o;
   assign pop  = out_valid_o & out_ready_i;

   // Shift-out storage, head always at entry zero
   always_comb begin
      s_d = s_q;
      if (pop) begin
         s_d.mem[0] = s_q.mem[1];
      end
      if (push) begin
         if (s_q.cnt == 2'h0 || (s_q.cnt == 2'h1 && pop)) begin
            s_d.mem[0] = in_data_i;
         end else begin
            s_d.mem[1] = in_data_i;
         end
      end
      s_d.cnt = s_q.cnt + {1'b0, push} - {1'b0, pop};
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s_q <= '0;
      end else if (en_i) begin
         s_q <= s_d;
      end
   end

   a_buf_no_over : assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      s_q.cnt <= 2'h2) else $error("buffer count overflow");
endmodule
`default_nettype wire

// [hdl/jtlt_core.sv]
// Transmit link timing: sync, comma phase, trigger latency and wake timers
`timescale 1ns/1ps
`default_nettype none
module jtlt_core
   import jtlt_pkg::*;
(
   // Clock, reset, enable
   input  wire logic       ref_clk_i,
   input  wire logic       nrst_i,
   input  wire logic       clk_en_i,
   // Configuration
   input  wire logic [1:0] rate_mode_i,       // 0..3 = modes one to four
   input  wire logic       four_lane_i,
   input  wire logic       rf_decim_en_i,
   input  wire logic       standby_i,
   input  wire logic       power_down_i,
   // Link control
   input  wire logic       link_sync_request_in_n_i,
   input  wire logic       transmit_trigger_in_i,
   // Character stream
   output logic            char_valid_o,
   input  wire logic       char_ready_i,
   output logic [7:0]      char_data_o,
   output logic            char_is_k_o,
   // Status
   output logic            link_valid_o,
   output logic            dev_ready_o,
   output logic            cfg_error_o,
   output logic            code_group_sync_phase_o
);
   import jtlt_pkg::*;

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      jtlt_state_t        st;
      logic               sync_d;
      logic [5:0]         mf;
      logic [2:0]         mfcnt;
      logic [5:0]         lat;
      logic               lat_run;
      logic [WAKE_W-1:0]  lock;
      logic [WAKE_W-1:0]  wake;
      logic [WAKE_W-1:0]  lnk;
      logic               stby_d;
      logic               pdwn_d;
      logic               start_pend;
   } jtlt_core_t;
   jtlt_core_t s_q, s_d;

   logic       push, in_ready, locked, woke, link_up, lat_done;
   logic [8:0] push_data, out_data;
   logic [5:0] lat_tgt;

   // Lane bit period is L/(UI_FACTOR*M*fs); it is set by the serializer, not here
   assign lat_tgt = four_lane_i ? LAT4[rate_mode_i] : LAT2[rate_mode_i];
   // Modes three and four without the decimator are flagged, not corrected
   assign cfg_error_o = rate_mode_i[1] & ~rf_decim_en_i;
   assign locked  = (s_q.lock >= WAKE_W'(LOCK_CYC));
   assign woke    = (s_q.wake == '0);
   assign link_up = (s_q.lnk == '0);
   // Ready stays low while asleep; the registered levels are used so that no
   // pulse slips out in the cycle before the wake timer loads
   assign dev_ready_o  = locked & woke & ~s_q.stby_d & ~s_q.pdwn_d;
   assign link_valid_o = dev_ready_o & link_up;
   assign code_group_sync_phase_o = (s_q.st == JT_CGS);

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      s_d = s_q;
      push = 1'b0;
      push_data = 9'h000;
      lat_done = 1'b0;
      s_d.sync_d = link_sync_request_in_n_i;
      s_d.stby_d = standby_i;
      s_d.pdwn_d = power_down_i;
      s_d.mf = (s_q.mf == MF_LAST) ? 6'h00 : s_q.mf + 6'h01;
      // Lock counter counts once up to LOCK_CYC and only holds while the sample clock is held off
      if (!locked) begin
         s_d.lock = s_q.lock + WAKE_W'(1);
      end
      // Wake timers load on leaving standby or power-down
      if (s_q.wake != '0) begin
         s_d.wake = s_q.wake - WAKE_W'(1);
      end
      if (s_q.lnk != '0) begin
         s_d.lnk = s_q.lnk - WAKE_W'(1);
      end
      if (s_q.stby_d && !standby_i) begin
         s_d.wake = WAKE_W'(STBY_CYC);
      end
      if (s_q.pdwn_d && !power_down_i) begin
         s_d.wake = WAKE_W'(PDWN_CYC);
         s_d.lnk  = WAKE_W'(LINK_CYC);
      end
      if (standby_i || power_down_i) begin
         s_d.st = JT_OFF;
      end
      // Trigger latency counter, started by a sampled trigger
      if (transmit_trigger_in_i && s_q.st == JT_DATA) begin
         s_d.lat_run = 1'b1;
         s_d.lat = 6'h01;
      end else if (s_q.lat_run) begin
         s_d.lat = s_q.lat + 6'h01;
         if (s_q.lat == lat_tgt - 6'h01) begin
            s_d.lat_run = 1'b0;
            lat_done = 1'b1;
         end
      end
      case (s_q.st)
         JT_OFF: begin
            if (link_valid_o && !standby_i && !power_down_i) begin
               s_d.st = JT_DATA;
            end
         end
         JT_WAIT: begin
            // Count whole multiframes from the falling edge of the request
            if (s_q.mf == MF_LAST) begin
               s_d.mfcnt = s_q.mfcnt + 3'h1;
               if (s_q.mfcnt == SYNC_WAIT_LAST) begin
                  s_d.st = JT_CGS;
                  s_d.mfcnt = 3'h0;
               end
            end
         end
         JT_CGS: begin
            push = 1'b1;
            push_data = {1'b1, K28_5};
            if (in_ready && s_q.mf == MF_LAST) begin
               s_d.mfcnt = 3'h1;
            end
            // Leave only after a full multiframe and the receiver release
            if (s_q.mfcnt != 3'h0 && link_sync_request_in_n_i) begin
               s_d.st = JT_DATA;
            end
         end
         default: begin
            if (s_q.start_pend) begin
               push = 1'b1;
               push_data = {1'b1, START_CODE};
               if (in_ready) begin
                  s_d.start_pend = 1'b0;
               end
            end
         end
      endcase
      // Set after the push clears, so a count ending as an older start code
      // leaves does not lose the new one
      if (lat_done) begin
         s_d.start_pend = 1'b1;
      end
      // A fresh sync request restarts the link from any state except JT_OFF
      if (s_q.sync_d && !link_sync_request_in_n_i && s_q.st != JT_OFF) begin
         s_d.st = JT_WAIT;
         s_d.mf = 6'h00;
         s_d.mfcnt = 3'h0;
      end
   end

   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s_q <= '{st: JT_OFF, sync_d: 1'b1, default: '0};
      end else if (clk_en_i) begin
         s_q <= s_d;
      end
   end

   // ----------------------------------------------------------------
   // Output buffer, a receiver stall holds up to three start codes (two here, one pending) and loses later ones; commas pushed while it is full are dropped
   // ----------------------------------------------------------------
   jtlt_buf u_buf (
      .ref_clk_i   (ref_clk_i),
      .nrst_i      (nrst_i),
      .en_i        (clk_en_i),
      .in_valid_i  (push),
      .in_ready_o  (in_ready),
      .in_data_i   (push_data),
      .out_valid_o (char_valid_o),
      .out_ready_i (char_ready_i),
      .out_data_o  (out_data)
   );
   assign char_data_o = out_data[7:0];
   assign char_is_k_o = out_data[8];

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   sequence sync_fall_s;
      $fell(link_sync_request_in_n_i) && s_q.st != JT_OFF && !standby_i && !power_down_i;
   endsequence
   a_sync_no_early : assert property (@(posedge ref_clk_i) disable iff (!nrst_i || !clk_en_i)
      sync_fall_s |=> s_q.st != JT_CGS [*8]) else $error("commas too early");
   a_cgs_min_len : assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      $rose(s_q.st == JT_CGS) |-> s_q.mfcnt == 3'h0) else $error("comma phase short");
   a_cgs_exit_ok : assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      s_q.st == JT_CGS && s_d.st == JT_DATA && clk_en_i |-> s_q.mfcnt != 3'h0)
      else $error("left comma phase early");
   a_lat_table : assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      four_lane_i && rate_mode_i == 2'h1 |-> lat_tgt == 6'h2a) else $error("bad latency");
   a_lat_two : assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      !four_lane_i && rate_mode_i == 2'h1 |-> lat_tgt == 6'h21) else $error("bad latency");
   a_lat_done : assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      $fell(s_q.lat_run) && !$past(transmit_trigger_in_i) |-> s_q.start_pend)
      else $error("latency end lost");
   a_valid_lock : assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      link_valid_o |-> s_q.lock >= WAKE_W'(LOCK_CYC)) else $error("valid before lock");
   a_wake_time : assert property (@(posedge ref_clk_i) disable iff (!nrst_i || !clk_en_i)
      $fell(standby_i) && !power_down_i |=> s_q.wake == WAKE_W'(STBY_CYC))
      else $error("standby wake not loaded");
   a_pdwn_link : assert property (@(posedge ref_clk_i) disable iff (!nrst_i || !clk_en_i)
      $fell(power_down_i) |=> s_q.lnk == WAKE_W'(LINK_CYC)) else $error("link wake not loaded");
   a_cfg_flag : assert property (@(posedge ref_clk_i) disable iff (!nrst_i)
      rate_mode_i[1] && !rf_decim_en_i |-> cfg_error_o) else $error("decimator check");
endmodule
`default_nettype wire

// [tb/jtlt_rx_model.sv]
// Receiver model: sync request source and character sink
`timescale 1ns/1ps
`default_nettype none
module jtlt_rx_model (
   // Clock and reset
   input  wire logic       ref_clk_i,
   input  wire logic       nrst_i,
   // Bench control
   input  wire logic       sync_go_i,
   input  wire logic       stall_i,
   // Character stream and sync request
   input  wire logic       char_valid_i,
   input  wire logic [7:0] char_data_i,
   input  wire logic       char_is_k_i,
   output logic            char_ready_o,
   output logic            sync_n_o
);
   logic [2:0] n_comma_q;
   // Ready follows the stall switch only, so the bench can fill the buffer
   assign char_ready_o = !stall_i;
   // Request stays low until four commas in a row have arrived
   always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         sync_n_o  <= 1'b1;
         n_comma_q <= 3'h0;
      end else if (sync_go_i) begin
         sync_n_o  <= 1'b0;
         n_comma_q <= 3'h0;
      end else if (char_valid_i && char_ready_o) begin
         if (char_data_i == 8'hbc && char_is_k_i) begin
            n_comma_q <= n_comma_q + 3'h1;
            if (n_comma_q == 3'h3) sync_n_o <= 1'b1;
         end else begin
            n_comma_q <= 3'h0;
         end
      end
   end
endmodule
`default_nettype wire

// [tb/testbench.sv]
// Self-checking testbench for the transmit link timing core
`timescale 1ns/1ps
`default_nettype none
module testbench;
   import jtlt_pkg::*;
   // ----------------------------------------
   // Signals, clock, instances
   // ----------------------------------------
   logic       clk, nrst, four, decim, stby, pdwn, trig, go, stall, en;
   logic [1:0] mode;
   logic       cv, rdy, ck, syn, lv, dr, ce, code_group_sync_phase;
   logic [7:0] cd;
   int         mismatches, n_checks, k, n, lat;
   // Sample clock, 8 ns period
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   jtlt_core dut (.ref_clk_i(clk), .nrst_i(nrst), .clk_en_i(en), .rate_mode_i(mode),
      .four_lane_i(four), .rf_decim_en_i(decim), .standby_i(stby), .power_down_i(pdwn),
      .link_sync_request_in_n_i(syn), .transmit_trigger_in_i(trig), .char_valid_o(cv),
      .char_ready_i(rdy), .char_data_o(cd), .char_is_k_o(ck), .link_valid_o(lv),
      .dev_ready_o(dr), .cfg_error_o(ce), .code_group_sync_phase_o(code_group_sync_phase));
   jtlt_rx_model rx (.ref_clk_i(clk), .nrst_i(nrst), .sync_go_i(go), .stall_i(stall),
      .char_valid_i(cv), .char_data_i(cd), .char_is_k_i(ck), .char_ready_o(rdy),
      .sync_n_o(syn));
   // Inputs always move 1 ns after the rising edge, away from sampling
   task cyc(input int c);
      repeat (c) @(posedge clk);
      #1;
   endtask
   task chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("[ERR] %s exp %0h got %0h", nm, exp, got);
      end
   endtask
   task test_done;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   // Bounded wait at falling edges; sel 0 link valid, 1 ready, 2 char valid
   task automatic wait_up(input int sel, input int lim, output int cnt);
      logic s;
      for (cnt = 1; cnt <= lim; cnt++) begin
         @(negedge clk);
         s = (sel == 0) ? lv : (sel == 1) ? dr : cv;
         if (s === 1'b1) return;
      end
      $display("[ERR] wait %0d exp high got timeout", sel);
      mismatches++;
      test_done();
   endtask
   task t_lock;
      cyc(LOCK_CYC - 10);
      chk("lv_early", 0, lv);
      wait_up(0, 30, k);
      chk("dr_lock", 1, dr);
      $display("t_lock done");
   endtask
   task t_sync;
      cyc(2);
      go = 1'b1;
      cyc(1);
      go = 1'b0;
      wait_up(2, 200, k);
      chk("comma_delay", 1, k >= 4 * MF_CYC && k <= 4 * MF_CYC + 6);
      chk("comma", K28_5, cd);
      chk("comma_k", 1, ck);
      chk("cgs_on", 1, code_group_sync_phase);
      n = 0;
      for (int i = 0; i < 400 && code_group_sync_phase === 1'b1; i++) begin
         if (cv === 1'b1 && rdy === 1'b1 && cd === K28_5) n++;
         @(negedge clk);
      end
      chk("cgs_len", 1, n >= MF_CYC * CGS_MIN_MF);
      chk("cgs_end", 0, code_group_sync_phase);
      $display("t_sync done");
   endtask
   task t_cfg;
      cyc(1);
      decim = 1'b0;
      for (int m = 0; m < 4; m++) begin
         mode = m[1:0];
         cyc(1);
         chk("cfg_err", m >= 2, ce);
      end
      decim = 1'b1;
      cyc(1);
      chk("cfg_err_dec", 0, ce);
      $display("t_cfg done");
   endtask
   // Every mode in both lane counts; the decimator is set as config must
   task t_lat;
      for (int f = 0; f < 2; f++)
         for (int m = 0; m < 4; m++) begin
            four = f[0];
            mode = m[1:0];
            decim = m >= 2;
            cyc(4);
            trig = 1'b1;
            cyc(1);
            trig = 1'b0;
            lat = f ? LAT4[m] : LAT2[m];
            wait_up(2, 80, k);
            chk("start", START_CODE, cd);
            chk("start_k", 1, ck);
            // Start code shows after edge trigger+lat, seen at the following negedge
            chk("latency", 1, k == lat + 1);
            cyc(1);
         end
      $display("t_lat done");
   endtask
   // Two start codes pile up while the receiver stalls; none may be lost
   task t_stall;
      stall = 1'b1;
      for (int i = 0; i < 2; i++) begin
         trig = 1'b1;
         cyc(1);
         trig = 1'b0;
         cyc(60);
      end
      chk("held_v", 1, cv);
      chk("held_d", START_CODE, cd);
      stall = 1'b0;
      n = 0;
      for (int i = 0; i < 8; i++) begin
         @(negedge clk);
         if (cv === 1'b1 && cd === START_CODE) n++;
      end
      chk("drained", 2, n);
      chk("empty", 0, cv);
      $display("t_stall done");
   endtask
   // Enable low freezes the latency count; the start code slips by the frozen cycles
   task t_hold;
      cyc(1);
      four = 1'b1;
      mode = 2'h3;
      decim = 1'b1;
      trig = 1'b1;
      cyc(1);
      trig = 1'b0;
      en = 1'b0;
      cyc(10);
      chk("hold_v", 0, cv);
      en = 1'b1;
      wait_up(2, 80, k);
      chk("hold_lat", LAT4[3] + 8'h01, k);
      chk("hold_start", START_CODE, cd);
      $display("t_hold done");
   endtask
   task t_wake;
      cyc(1);
      stby = 1'b1;
      cyc(5);
      chk("stby_lv", 0, lv);
      chk("stby_dr", 0, dr);
      stby = 1'b0;
      cyc(STBY_CYC - 10);
      chk("stby_early", 0, dr);
      wait_up(1, 30, k);
      cyc(1);
      pdwn = 1'b1;
      cyc(5);
      chk("pdwn_dr", 0, dr);
      pdwn = 1'b0;
      cyc(PDWN_CYC - 20);
      chk("pdwn_early", 0, dr);
      wait_up(1, 50, k);
      $display("t_wake done");
   endtask
   // Reset for four cycles, then the scenarios in turn
   initial begin
      nrst = 1'b0;
      mode = 2'h0;
      {four, decim, stby, pdwn, trig, go, stall} = 7'h00;
      en = 1'b1;
      mismatches = 0;
      n_checks = 0;
      cyc(4);
      nrst = 1'b1;
      t_lock();
      t_sync();
      t_cfg();
      t_lat();
      t_stall();
      t_hold();
      t_wake();
      test_done();
   end
endmodule
`default_nettype wire
